// ===== pkg/hpa_pkg.sv
package hpa_pkg;

	// register bus
	localparam int BUS_AW = 8;
	localparam logic [7:0] OFS_COMMAND = 8'h00;
	localparam logic [7:0] OFS_FEATURES = 8'h04;
	localparam logic [7:0] OFS_SECTOR_COUNT = 8'h08;
	localparam logic [7:0] OFS_LBA = 8'h0C;
	localparam logic [7:0] OFS_PW_INDEX = 8'h10;
	localparam logic [7:0] OFS_PW_DATA = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_RESULT = 8'h1C;
	localparam logic [7:0] OFS_CUR_MAX = 8'h20;
	localparam logic [7:0] OFS_ID_CAPS = 8'h24;
	localparam logic [7:0] OFS_ID_STATE = 8'h28;
	localparam logic [7:0] OFS_ID_CAPACITY = 8'h2C;
	localparam logic [7:0] OFS_NV_MAX = 8'h30;

	// command codes and set-max subcommands
	localparam logic [7:0] CMD_READ_NATIVE = 8'hF8;
	localparam logic [7:0] CMD_SET_MAX = 8'hF9;
	localparam logic [7:0] CMD_READ_SECT = 8'h20;
	localparam logic [7:0] CMD_WRITE_SECT = 8'h30;
	localparam logic [7:0] FEAT_ADDR = 8'h00;
	localparam logic [7:0] FEAT_PASSWORD = 8'h01;
	localparam logic [7:0] FEAT_LOCK = 8'h02;
	localparam logic [7:0] FEAT_UNLOCK = 8'h03;
	localparam logic [7:0] FEAT_FREEZE = 8'h04;
	localparam int VOL_BIT = 0;

	// status fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_ERR = 1;
	localparam int STAT_ABRT = 2;
	localparam int STAT_IDNF = 3;
	localparam int STAT_SEC = 4;
	localparam int STAT_PWV = 6;

	// identify bits
	localparam int ID82_HPA_BIT = 10;
	localparam int ID83_EXT_BIT = 8;
	localparam int ID86_EXT_BIT = 8;

	// reset values and counts
	localparam logic [27:0] NATIVE_MAX_DFLT = 28'hFFFFFFF;
	localparam logic [1:0] INIT_LOAD_CNT = 2'h2;
	localparam logic [1:0] HW_SYNC_RST = 2'h3;

	typedef enum logic [1:0] {SEC_INACTIVE, SEC_UNLOCKED, SEC_LOCKED, SEC_FROZEN} sec_state_t;
	typedef enum logic [1:0] {C_IDLE, C_PW_WR, C_PW_RD, C_PW_CMP} cmd_state_t;

endpackage

// ===== pkg/pw_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pw_mem_if #(
	parameter int AW = 3
);
	logic we;
	logic [AW-1:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	modport ctrl (output we, output addr, output wdata, input rdata);
	modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== src/pw_store.sv
`timescale 1ns/100ps
`default_nettype none
module pw_store #(
	parameter int DEPTH = 8
)(
	// clock
	input wire logic i_core_clk,
	// access port
	pw_mem_if.mem port
);
	logic [31:0] mem_r [DEPTH];

	// no reset: contents only count once the controller marks them valid
	always_ff @(posedge i_core_clk)
	begin
		if (port.we)
			mem_r[port.addr] <= port.wdata;
		port.rdata <= mem_r[port.addr];
	end
endmodule
`default_nettype wire

// ===== src/host_protected_area_ctrl.sv
// Operation
// (R1) identify word 82 bit 10 reads one: reserved-area feature supported.
// (R2) with password extensions, identify word 83 bit 8 also reads one.
// (R3) set-max subcommands share one code, chosen by the features value.
// (R4) read-native-maximum always returns the true native maximum.
// (R5) a set maximum below native limits user space; above is reserved.
// (R6) host sends read-native-maximum right before every set-maximum.
// (R7) identify capacity reports only the reduced maximum after set-maximum.
// (R8) media access above current maximum ends with idnf and err.
// (R9) sector count volatility bit picks whether the new maximum persists.
// (R10) power-on or hardware reset restores last non-volatile maximum.
// (R11) set-maximum above native maximum is aborted.
// (R12) only one non-volatile set-maximum per reset; a second is aborted.
// (R13) host uses one addressing form for all these commands.
// (R14) password survives hardware and software reset, lost on power cycle.
// (R15) reserved-area password kept apart from the security-mode password.
// (R16) accepted set-password enters the unlocked state.
// (R17) accepted lock enters locked; only unlock works until unlock or power cycle. Here a lock while locked is also accepted.
// (R18) accepted unlock moves locked back to unlocked.
// (R19) accepted freeze enters frozen until power cycle, blocking even unlock.
// (R20) power-on starts inactive: lock, unlock, freeze abort; set-maximum runs.
// (R21) set-password while unlocked replaces the stored password.
// (R22) while locked, identify word 86 bit 8 reads one.
// (R23) frozen aborts every set-max subcommand and stays frozen.
// (R24) unlock with a wrong password is aborted and stays locked.
`timescale 1ns/100ps
`default_nettype none
module host_protected_area_ctrl #(
	parameter int ADDR_W = 28,
	parameter logic [ADDR_W-1:0] NATIVE_MAX = hpa_pkg::NATIVE_MAX_DFLT,
	parameter int PW_WORDS = 8,
	parameter bit PW_EXT = 1'b1
)(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// avalon-mm slave
	input wire logic [hpa_pkg::BUS_AW-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// hardware reset pin and persistent maximum
	input wire logic i_hw_reset_n,
	input wire logic [ADDR_W-1:0] i_nv_max,
	output logic o_nv_write,
	output logic [ADDR_W-1:0] o_nv_max_addr,
	// media access
	output logic o_media_req,
	output logic o_media_write,
	output logic [ADDR_W-1:0] o_media_lba
);
	import hpa_pkg::*;

	localparam int PW_AW = (PW_WORDS > 1) ? $clog2(PW_WORDS) : 1;
	localparam logic [PW_AW-1:0] PW_LAST = PW_AW'(PW_WORDS - 1);

	function automatic logic reg_hit(input logic [BUS_AW-1:0] a, input logic [BUS_AW-1:0] ofs);
		return a[BUS_AW-1:2] == ofs[BUS_AW-1:2];
	endfunction

	logic [1:0] hw_sync_r;
	logic [ADDR_W-1:0] nv_sync0_r, nv_sync1_r;
	logic [1:0] init_cnt_r;
	logic ready_r, init_load, hw_rst;
	logic accept, wr_acc, rd_acc;
	logic [7:0] feat_r, count_r, cmd_r;
	logic [ADDR_W-1:0] lba_r, cur_max_r, nv_max_r, result_r, nv_init;
	logic [PW_AW-1:0] pw_idx_r, widx_r;
	logic [31:0] stage_r [PW_WORDS];
	logic cmd_go_r, busy_r, err_r, abrt_r, idnf_r, nv_done_r, rnm_prev_r, pw_valid_r, miss_r;
	sec_state_t sec_r, sec_nxt;
	cmd_state_t cst_r;
	logic exec, v_abort, v_idnf, v_setmax, v_nv, v_pw, v_unl, v_media, v_rnm;
	logic cmp_miss, fin_pw, fin_unl;
	logic [15:0] id_w82, id_w83, id_w86;
	logic [31:0] id_cap, rd_mux;

	pw_mem_if #(.AW(PW_AW)) pw_bus ();

	// own store, never shared with the security-mode password R15
	pw_store #(.DEPTH(PW_WORDS)) u_store (
		.i_core_clk(i_core_clk),
		.port(pw_bus.mem)
	);

	assign pw_bus.we = (cst_r == C_PW_WR);
	assign pw_bus.addr = widx_r;
	assign pw_bus.wdata = stage_r[widx_r];
	assign cmp_miss = (pw_bus.rdata != stage_r[widx_r]);
	assign fin_pw = (cst_r == C_PW_WR) && (widx_r == PW_LAST);
	assign fin_unl = (cst_r == C_PW_CMP) && (widx_r == PW_LAST);

	// pin inputs cross through two flops
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			hw_sync_r <= HW_SYNC_RST;
			nv_sync0_r <= '0;
			nv_sync1_r <= '0;
		end
		else
		begin
			hw_sync_r <= {hw_sync_r[0], i_hw_reset_n};
			nv_sync0_r <= i_nv_max;
			nv_sync1_r <= nv_sync0_r;
		end
	end
	assign hw_rst = ~hw_sync_r[1];

	// persistent maximum is caught after release; the bus stalls until then
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			init_cnt_r <= '0;
			ready_r <= 1'b0;
		end
		else if (!ready_r)
		begin
			init_cnt_r <= init_cnt_r + 1'b1;
			ready_r <= (init_cnt_r == INIT_LOAD_CNT);
		end
	end
	assign init_load = !ready_r && (init_cnt_r == INIT_LOAD_CNT);
	assign nv_init = (nv_sync1_r > NATIVE_MAX) ? NATIVE_MAX : nv_sync1_r;

	// bus slave: waitrequest drops for exactly one cycle per accepted request
	assign accept = (i_avs_read | i_avs_write) && o_avs_waitrequest && ready_r;
	assign wr_acc = accept && i_avs_write;
	assign rd_acc = accept && i_avs_read;

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
			o_avs_waitrequest <= 1'b1;
		else
			o_avs_waitrequest <= !accept;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			feat_r <= '0;
			count_r <= '0;
			lba_r <= '0;
			cmd_r <= '0;
			pw_idx_r <= '0;
			cmd_go_r <= 1'b0;
		end
		else
		begin
			// a command written while busy is dropped
			cmd_go_r <= wr_acc && reg_hit(i_avs_address, OFS_COMMAND) && !busy_r;
			if (wr_acc && reg_hit(i_avs_address, OFS_COMMAND) && !busy_r)
				cmd_r <= i_avs_writedata[7:0];
			if (wr_acc && reg_hit(i_avs_address, OFS_FEATURES))
				feat_r <= i_avs_writedata[7:0];
			if (wr_acc && reg_hit(i_avs_address, OFS_SECTOR_COUNT))
				count_r <= i_avs_writedata[7:0];
			if (wr_acc && reg_hit(i_avs_address, OFS_LBA))
				lba_r <= i_avs_writedata[ADDR_W-1:0];
			if (wr_acc && reg_hit(i_avs_address, OFS_PW_INDEX))
				pw_idx_r <= i_avs_writedata[PW_AW-1:0];
			else if (wr_acc && reg_hit(i_avs_address, OFS_PW_DATA))
				pw_idx_r <= pw_idx_r + 1'b1;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (wr_acc && reg_hit(i_avs_address, OFS_PW_DATA))
			stage_r[pw_idx_r] <= i_avs_writedata;
	end

	// command decode and verdict
	always_comb
	begin
		exec = cmd_go_r && (cst_r == C_IDLE);
		v_abort = 1'b0;
		v_idnf = 1'b0;
		v_setmax = 1'b0;
		v_nv = 1'b0;
		v_pw = 1'b0;
		v_unl = 1'b0;
		v_media = 1'b0;
		v_rnm = 1'b0;
		sec_nxt = sec_r;
		if (cmd_r == CMD_READ_NATIVE)
			v_rnm = 1'b1; // R4
		else if (cmd_r == CMD_SET_MAX)
		begin
			case (feat_r) // R3
				FEAT_ADDR:
				begin
					if (sec_r == SEC_LOCKED || sec_r == SEC_FROZEN || !rnm_prev_r) // R6 R17 R23
						v_abort = 1'b1;
					else if (lba_r > NATIVE_MAX) // R11
						v_abort = 1'b1;
					else if (count_r[VOL_BIT] && nv_done_r) // R12
						v_abort = 1'b1;
					else
					begin
						v_setmax = 1'b1; // R5 R20
						v_nv = count_r[VOL_BIT]; // R9
					end
				end
				FEAT_PASSWORD:
				begin
					if (sec_r == SEC_LOCKED || sec_r == SEC_FROZEN) // R17 R23
						v_abort = 1'b1;
					else
						v_pw = 1'b1; // R21
				end
				FEAT_LOCK:
				begin
					if (sec_r == SEC_INACTIVE || sec_r == SEC_FROZEN) // R20 R23
						v_abort = 1'b1;
					else
						sec_nxt = SEC_LOCKED; // R17
				end
				FEAT_UNLOCK:
				begin
					if (sec_r == SEC_LOCKED)
						v_unl = 1'b1; // R18
					else
						v_abort = 1'b1; // R19 R20
				end
				FEAT_FREEZE:
				begin
					if (sec_r == SEC_UNLOCKED)
						sec_nxt = SEC_FROZEN; // R19
					else
						v_abort = 1'b1; // R17 R20 R23
				end
				default:
					v_abort = 1'b1;
			endcase
		end
		else if (cmd_r == CMD_READ_SECT || cmd_r == CMD_WRITE_SECT)
		begin
			if (lba_r > cur_max_r)
				v_idnf = 1'b1; // R8
			else
				v_media = 1'b1;
		end
		else
			v_abort = 1'b1;
	end

	// password write and compare walk
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			cst_r <= C_IDLE;
			widx_r <= '0;
			miss_r <= 1'b0;
		end
		else
		begin
			unique case (cst_r)
				C_IDLE:
				begin
					widx_r <= '0;
					miss_r <= 1'b0;
					if (exec && v_pw)
						cst_r <= C_PW_WR;
					else if (exec && v_unl)
						cst_r <= C_PW_RD;
				end
				C_PW_WR:
				begin
					widx_r <= widx_r + 1'b1;
					if (fin_pw)
						cst_r <= C_IDLE;
				end
				C_PW_RD:
					cst_r <= C_PW_CMP;
				C_PW_CMP:
				begin
					miss_r <= miss_r | cmp_miss;
					widx_r <= widx_r + 1'b1;
					cst_r <= fin_unl ? C_IDLE : C_PW_RD;
				end
			endcase
		end
	end

	// lock state; hardware reset leaves it and the password alone R14
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			sec_r <= SEC_INACTIVE; // R20
			pw_valid_r <= 1'b0;
		end
		else if (fin_pw)
		begin
			sec_r <= SEC_UNLOCKED; // R16
			pw_valid_r <= 1'b1;
		end
		else if (fin_unl && !(miss_r || cmp_miss))
			sec_r <= SEC_UNLOCKED; // R18 R24
		else if (exec && !v_abort)
			sec_r <= sec_nxt;
	end

	// maximum address bookkeeping
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			cur_max_r <= NATIVE_MAX;
			nv_max_r <= NATIVE_MAX;
			nv_done_r <= 1'b0;
			rnm_prev_r <= 1'b0;
			o_nv_write <= 1'b0;
		end
		else
		begin
			o_nv_write <= exec && v_nv;
			if (init_load)
			begin
				cur_max_r <= nv_init; // R10
				nv_max_r <= nv_init;
			end
			else if (hw_rst)
			begin
				cur_max_r <= nv_max_r; // R10
				nv_done_r <= 1'b0;
				rnm_prev_r <= 1'b0;
			end
			else if (exec)
			begin
				rnm_prev_r <= v_rnm; // R6
				if (v_setmax)
					cur_max_r <= lba_r; // R5
				if (v_nv)
				begin
					nv_max_r <= lba_r; // R9
					nv_done_r <= 1'b1; // R12
				end
			end
		end
	end
	assign o_nv_max_addr = nv_max_r;

	// completion status of the last command
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			busy_r <= 1'b0;
			err_r <= 1'b0;
			abrt_r <= 1'b0;
			idnf_r <= 1'b0;
			result_r <= '0;
		end
		else if (wr_acc && reg_hit(i_avs_address, OFS_COMMAND) && !busy_r)
		begin
			busy_r <= 1'b1;
			err_r <= 1'b0;
			abrt_r <= 1'b0;
			idnf_r <= 1'b0;
		end
		else if (exec && !v_pw && !v_unl)
		begin
			busy_r <= 1'b0;
			abrt_r <= v_abort;
			idnf_r <= v_idnf; // R8
			err_r <= v_abort | v_idnf;
			if (v_rnm)
				result_r <= NATIVE_MAX; // R4
		end
		else if (fin_pw)
			busy_r <= 1'b0;
		else if (fin_unl)
		begin
			busy_r <= 1'b0;
			abrt_r <= miss_r | cmp_miss; // R24
			err_r <= miss_r | cmp_miss;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			o_media_req <= 1'b0;
			o_media_write <= 1'b0;
			o_media_lba <= '0;
		end
		else
		begin
			o_media_req <= exec && v_media;
			if (exec && v_media)
			begin
				o_media_write <= (cmd_r == CMD_WRITE_SECT);
				o_media_lba <= lba_r;
			end
		end
	end

	// identify words and read mux
	always_comb
	begin
		id_w82 = '0;
		id_w83 = '0;
		id_w86 = '0;
		id_w82[ID82_HPA_BIT] = 1'b1; // R1
		id_w83[ID83_EXT_BIT] = PW_EXT; // R2
		id_w86[ID86_EXT_BIT] = (sec_r != SEC_INACTIVE); // R22
		id_cap = 32'(cur_max_r) + 32'h1; // R7
		rd_mux = '0;
		if (reg_hit(i_avs_address, OFS_FEATURES))
			rd_mux = 32'(feat_r);
		else if (reg_hit(i_avs_address, OFS_SECTOR_COUNT))
			rd_mux = 32'(count_r);
		else if (reg_hit(i_avs_address, OFS_LBA))
			rd_mux = 32'(lba_r);
		else if (reg_hit(i_avs_address, OFS_PW_INDEX))
			rd_mux = 32'(pw_idx_r);
		else if (reg_hit(i_avs_address, OFS_STATUS))
			rd_mux = 32'({pw_valid_r, sec_r, idnf_r, abrt_r, err_r, busy_r});
		else if (reg_hit(i_avs_address, OFS_RESULT))
			rd_mux = 32'(result_r);
		else if (reg_hit(i_avs_address, OFS_CUR_MAX))
			rd_mux = 32'(cur_max_r);
		else if (reg_hit(i_avs_address, OFS_ID_CAPS))
			rd_mux = {id_w83, id_w82};
		else if (reg_hit(i_avs_address, OFS_ID_STATE))
			rd_mux = 32'(id_w86);
		else if (reg_hit(i_avs_address, OFS_ID_CAPACITY))
			rd_mux = id_cap;
		else if (reg_hit(i_avs_address, OFS_NV_MAX))
			rd_mux = 32'(nv_max_r);
	end

	// password data never reads back
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
			o_avs_readdata <= '0;
		else if (rd_acc)
			o_avs_readdata <= rd_mux;
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_pw_go;
		exec && v_pw && (sec_r == SEC_INACTIVE);
	endsequence
	sequence s_unlock_bad;
		fin_unl && (miss_r || cmp_miss);
	endsequence

	AST_ID_HPA: assert property (id_w82[ID82_HPA_BIT]) else $error("hpa bit clear"); // R1
	AST_ID_EXT: assert property (id_w83[ID83_EXT_BIT] == PW_EXT) else $error("ext bit wrong"); // R2
	AST_BAD_SUB: assert property (exec && cmd_r == CMD_SET_MAX && feat_r > FEAT_FREEZE |=> abrt_r && err_r) // R3
		else $error("unknown subcommand not aborted");
	AST_NATIVE: assert property (exec && cmd_r == CMD_READ_NATIVE |=> result_r == NATIVE_MAX && !err_r) // R4
		else $error("native max wrong");
	AST_LIMIT: assert property (exec && v_setmax |=> cur_max_r == $past(lba_r)) // R5
		else $error("maximum not applied");
	AST_RNM_FIRST: assert property (exec && cmd_r == CMD_SET_MAX && feat_r == FEAT_ADDR && !rnm_prev_r |=> abrt_r) // R6
		else $error("set max without native read");
	AST_IDNF: assert property (exec && v_media == 1'b0 && cmd_r == CMD_READ_SECT && lba_r > cur_max_r // R8
		|=> idnf_r && err_r && !o_media_req) else $error("out of range access");
	AST_VOLATILE: assert property (exec && v_setmax && !count_r[VOL_BIT] |=> !o_nv_write && $stable(nv_max_r)) // R9
		else $error("volatile set persisted");
	AST_HW_RESTORE: assert property (ready_r && hw_rst |=> cur_max_r == $past(nv_max_r)) // R10
		else $error("hw reset did not restore");
	AST_OVER_NATIVE: assert property (exec && cmd_r == CMD_SET_MAX && feat_r == FEAT_ADDR && lba_r > NATIVE_MAX // R11
		|=> abrt_r && $stable(cur_max_r)) else $error("over native accepted");
	AST_ONE_NV: assert property (exec && cmd_r == CMD_SET_MAX && feat_r == FEAT_ADDR && count_r[VOL_BIT] && nv_done_r // R12
		|=> abrt_r && !o_nv_write) else $error("second nv set accepted");
	AST_PW_KEEP: assert property (hw_rst && cst_r == C_IDLE && !exec |=> $stable(pw_valid_r) && $stable(sec_r)) // R14
		else $error("hw reset touched password state");
	AST_PW_SET: assert property (s_pw_go |-> ##[1:20] sec_r == SEC_UNLOCKED) // R16
		else $error("set password did not unlock");
	AST_LOCK: assert property (exec && cmd_r == CMD_SET_MAX && feat_r == FEAT_LOCK && sec_r == SEC_UNLOCKED // R17
		|=> sec_r == SEC_LOCKED) else $error("lock not entered");
	AST_FROZEN: assert property (sec_r == SEC_FROZEN |=> sec_r == SEC_FROZEN) else $error("left frozen"); // R19
	AST_INACTIVE: assert property (exec && cmd_r == CMD_SET_MAX && sec_r == SEC_INACTIVE && feat_r >= FEAT_LOCK // R20
		&& feat_r <= FEAT_FREEZE |=> abrt_r && sec_r == SEC_INACTIVE) else $error("inactive accepted");
	AST_LOCKED_ID: assert property (sec_r == SEC_LOCKED |-> id_w86[ID86_EXT_BIT]) else $error("word 86 bit clear"); // R22
	AST_FROZEN_ABORT: assert property (exec && cmd_r == CMD_SET_MAX && sec_r == SEC_FROZEN |=> abrt_r) // R23
		else $error("frozen accepted");
	AST_UNLOCK_BAD: assert property (s_unlock_bad |=> sec_r == SEC_LOCKED && abrt_r) // R24
		else $error("bad password unlocked");

endmodule
`default_nettype wire

// ===== dv/nv_store_model.sv
`timescale 1ns/100ps
`default_nettype none
module nv_store_model #(
	parameter logic [27:0] INIT_MAX = 28'h0000F00
)(
	// clock
	input wire logic i_core_clk,
	// persist request from the device
	input wire logic i_nv_write,
	input wire logic [27:0] i_nv_max_addr,
	// stored value back to the device
	output logic [27:0] o_nv_max
);
	// survives both resets: only a persist pulse changes it
	logic [27:0] store_r = INIT_MAX;
	assign o_nv_max = store_r;
	always @(posedge i_core_clk)
	begin
		if (i_nv_write === 1'b1)
			store_r <= i_nv_max_addr;
	end
endmodule
`default_nettype wire

// ===== dv/host_protected_area_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none
module host_protected_area_ctrl_test;
	import hpa_pkg::*;
	localparam logic [27:0] NMAX = 28'h0001000;
	logic clk = 1'b0, rst_n = 1'b0, hw_n = 1'b1, rd = 1'b0, wr = 1'b0, w, nvw, mreq, mwr, wreq;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, rdata, got, em, mk, pa, pb, pc;
	logic [27:0] nvaddr, nvin, mlba, l;
	logic [28:0] mm;
	int fails = 0, num_checks = 0, seed = 7993;
	logic [31:0] exp_q[$], msk_q[$];
	logic [28:0] lba_q[$];
	logic [27:0] nv_q[$];
	always #10 clk = ~clk;
	host_protected_area_ctrl #(.NATIVE_MAX(NMAX), .PW_WORDS(2)) host_protected_area_ctrl_inst (
		.i_core_clk(clk), .i_reset_n(rst_n), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_hw_reset_n(hw_n),
		.i_nv_max(nvin), .o_nv_write(nvw), .o_nv_max_addr(nvaddr), .o_media_req(mreq),
		.o_media_write(mwr), .o_media_lba(mlba));
	nv_store_model nv_store_model_inst (.i_core_clk(clk), .i_nv_write(nvw), .i_nv_max_addr(nvaddr), .o_nv_max(nvin));
	task automatic bad(input string s);
		fails++;
		$display("ERROR t=%0t %s", $time, s);
	endtask
	// pre-edge values are what the edge samples, so no race with the design
	always @(posedge clk)
	begin
		if (rd && wreq === 1'b0 && msk_q.size() > 0)
		begin
			em = exp_q.pop_front();
			mk = msk_q.pop_front();
			if (mk != 32'h0)
			begin
				num_checks++;
				if ((rdata & mk) !== (em & mk)) bad($sformatf("read %h exp %h", rdata, em));
			end
		end
		if (mreq === 1'b1)
		begin
			num_checks++;
			if (lba_q.size() == 0) bad("unexpected media request");
			else begin mm = lba_q.pop_front(); if ({mwr, mlba} !== mm) bad("media request mismatch"); end
		end
		if (nvw === 1'b1)
		begin
			num_checks++;
			if (nv_q.size() == 0) bad("unexpected persist");
			else if (nvaddr !== nv_q.pop_front()) bad("persist value mismatch");
		end
	end
	// no local limit: a stalled slave is caught by the watchdog
	task automatic bus_op(input logic dir, input logic [7:0] a, input logic [31:0] d);
		rd <= !dir;
		wr <= dir;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (wreq !== 1'b0);
		got = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		bus_op(1'b1, a, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus_op(1'b0, a, 32'h0);
	endtask
	task automatic run_cmd(input logic [7:0] c);
		int n;
		n = 0;
		wr_reg(OFS_COMMAND, {24'h0, c});
		do begin rd_chk(OFS_STATUS, 32'h0, 32'h0); n++; end while (got[STAT_BUSY] !== 1'b0 && n < 50);
		if (n >= 50)
		begin
			bad("command hang");
			close_out();
		end
	endtask
	task automatic sm(input logic [7:0] f, input logic [31:0] sc, input logic [27:0] la);
		wr_reg(OFS_FEATURES, {24'h0, f});
		wr_reg(OFS_SECTOR_COUNT, sc);
		wr_reg(OFS_LBA, {4'h0, la});
		if (f == FEAT_ADDR) run_cmd(CMD_READ_NATIVE);
		run_cmd(CMD_SET_MAX);
	endtask
	task automatic stat(input logic ab, input logic id, input logic [1:0] st);
		rd_chk(OFS_STATUS, {26'h0, st, id, ab, ab | id, 1'b0}, 32'h3E);
	endtask
	task automatic pw(input logic [31:0] a, input logic [31:0] b);
		wr_reg(OFS_PW_INDEX, 32'h0);
		wr_reg(OFS_PW_DATA, a);
		wr_reg(OFS_PW_DATA, b);
	endtask
	task automatic pulse_reset(input logic pwr);
		if (pwr) rst_n <= 1'b0;
		else hw_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		hw_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#1_000_000;
		bad("watchdog expired");
		close_out();
	end
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(OFS_ID_CAPS, 32'h01000400, 32'h01000400);
		rd_chk(OFS_ID_STATE, 32'h0, 32'h100);
		rd_chk(8'h3C, 32'h0, 32'hFFFFFFFF);
		rd_chk(OFS_CUR_MAX, 32'h0F00, 32'h0FFFFFFF);
		$display("test reset done");
		wr_reg(OFS_LBA, 32'h800);
		run_cmd(CMD_SET_MAX);
		stat(1'b1, 1'b0, 2'h0);
		sm(FEAT_ADDR, 32'h0, 28'h800);
		stat(1'b0, 1'b0, 2'h0);
		rd_chk(OFS_CUR_MAX, 32'h800, 32'h0FFFFFFF);
		rd_chk(OFS_ID_CAPACITY, 32'h801, 32'h0FFFFFFF);
		run_cmd(CMD_READ_NATIVE);
		rd_chk(OFS_RESULT, {4'h0, NMAX}, 32'h0FFFFFFF);
		for (int i = 0; i < 6; i++)
		begin
			l = (i < 2) ? 28'h800 + 28'(i) : 28'($random(seed)) & 28'hFFF;
			w = i[0];
			wr_reg(OFS_LBA, {4'h0, l});
			if (l <= 28'h800) lba_q.push_back({w, l});
			run_cmd(w ? CMD_WRITE_SECT : CMD_READ_SECT);
			stat(1'b0, l > 28'h800, 2'h0);
		end
		$display("test limit done");
		sm(FEAT_ADDR, 32'h0, NMAX + 28'h1);
		stat(1'b1, 1'b0, 2'h0);
		sm(FEAT_ADDR, 32'h0, NMAX);
		stat(1'b0, 1'b0, 2'h0);
		nv_q.push_back(28'h900);
		sm(FEAT_ADDR, 32'h1, 28'h900);
		stat(1'b0, 1'b0, 2'h0);
		rd_chk(OFS_NV_MAX, 32'h900, 32'h0FFFFFFF);
		sm(FEAT_ADDR, 32'h1, 28'h950);
		stat(1'b1, 1'b0, 2'h0);
		sm(FEAT_ADDR, 32'h0, 28'h400);
		rd_chk(OFS_CUR_MAX, 32'h400, 32'h0FFFFFFF);
		pulse_reset(1'b0);
		rd_chk(OFS_CUR_MAX, 32'h900, 32'h0FFFFFFF);
		$display("test volatility done");
		for (logic [7:0] f = FEAT_LOCK; f <= FEAT_FREEZE; f++)
		begin
			sm(f, 32'h0, 28'h0);
			stat(1'b1, 1'b0, 2'h0);
		end
		sm(8'h05, 32'h0, 28'h0);
		stat(1'b1, 1'b0, 2'h0);
		pa = $random(seed);
		pb = $random(seed);
		pc = $random(seed);
		pw(pa, pb);
		sm(FEAT_PASSWORD, 32'h0, 28'h0);
		stat(1'b0, 1'b0, 2'h1);
		sm(FEAT_UNLOCK, 32'h0, 28'h0);
		stat(1'b1, 1'b0, 2'h1);
		sm(FEAT_LOCK, 32'h0, 28'h0);
		stat(1'b0, 1'b0, 2'h2);
		rd_chk(OFS_ID_STATE, 32'h100, 32'h100);
		sm(FEAT_ADDR, 32'h0, 28'h300);
		stat(1'b1, 1'b0, 2'h2);
		pw(pa, ~pb);
		sm(FEAT_UNLOCK, 32'h0, 28'h0);
		stat(1'b1, 1'b0, 2'h2);
		sm(FEAT_PASSWORD, 32'h0, 28'h0);
		stat(1'b1, 1'b0, 2'h2);
		pulse_reset(1'b0);
		pw(pa, pb);
		sm(FEAT_UNLOCK, 32'h0, 28'h0);
		stat(1'b0, 1'b0, 2'h1);
		pw(pc, pb);
		sm(FEAT_PASSWORD, 32'h0, 28'h0);
		sm(FEAT_LOCK, 32'h0, 28'h0);
		pw(pa, pb);
		sm(FEAT_UNLOCK, 32'h0, 28'h0);
		stat(1'b1, 1'b0, 2'h2);
		pw(pc, pb);
		sm(FEAT_UNLOCK, 32'h0, 28'h0);
		stat(1'b0, 1'b0, 2'h1);
		$display("test lock done");
		sm(FEAT_FREEZE, 32'h0, 28'h0);
		stat(1'b0, 1'b0, 2'h3);
		for (logic [7:0] f = FEAT_ADDR; f <= FEAT_FREEZE; f++)
		begin
			sm(f, 32'h0, 28'h300);
			stat(1'b1, 1'b0, 2'h3);
		end
		rd_chk(OFS_ID_STATE, 32'h100, 32'h100);
		pulse_reset(1'b1);
		rd_chk(OFS_STATUS, 32'h0, 32'h7E);
		rd_chk(OFS_CUR_MAX, 32'h900, 32'h0FFFFFFF);
		$display("test freeze done");
		if (lba_q.size() != 0 || nv_q.size() != 0) bad("pulses missing");
		close_out();
	end
endmodule
`default_nettype wire
